// [core/t16wm_consts.svh]
// t16wm_consts.svh: offsets, fields, modes and fixed tops of the waveform timer
// assumes a 32-bit classic wishbone slave, byte addresses, one word per register
// Contract
// - counter and flags run on clk_in; the timer tick is only an enable.
// - nonzero output-mode field hands the pin over to the waveform output.
// - pin driver enabled only when the direction bit selects output.
// - non-pwm: code 0 off, 1 toggle, 2 clear, 3 set on match.
// - fast pwm: code 2 clears on match, sets at bottom; code 3 inverse.
// - fast pwm code 1 toggles channel a only in modes 14, 15.
// - fast pwm codes 2, 3 with compare at top: match ignored, action done at top.
// - dual-slope code 1 toggles channel a only in modes 9, 11.
// - dual-slope code 2 clears on up match, sets on down; code 3 inverse.
// - mode field is high bits of control b over low bits of control a.
// - modes 0, 4, 12: tops max, compare a, capture; immediate load; flag at max.
// - modes 1-3, 10, 11: phase correct; load at top; flag at bottom.
// - modes 8, 9: capture or compare a top; load and flag at bottom.
// - modes 5-7, 14, 15: fast pwm; load at bottom; flag at top.
// - dual-slope compare at bottom stays low, at top stays high.
`ifndef T16WM_CONSTS_SVH
`define T16WM_CONSTS_SVH
`define T16WM_A_CTLA 8'h00
`define T16WM_A_CTLB 8'h04
`define T16WM_A_CMPA 8'h08
`define T16WM_A_CMPB 8'h0c
`define T16WM_A_CAPT 8'h10
`define T16WM_A_CNT  8'h14
`define T16WM_A_STAT 8'h18
`define T16WM_A_CLR  8'h1c
`define T16WM_A_IEN  8'h20
`define T16WM_A_DIR  8'h24
`define T16WM_F_COMA 7:6
`define T16WM_F_COMB 5:4
`define T16WM_F_WLO  1:0
`define T16WM_F_WHI  4:3
`define T16WM_I_OVF  0
`define T16WM_I_MA   1
`define T16WM_I_MB   2
`define T16WM_M_NORM 4'h0
`define T16WM_M_PC8  4'h1
`define T16WM_M_PC9  4'h2
`define T16WM_M_PC10 4'h3
`define T16WM_M_CTCA 4'h4
`define T16WM_M_FP8  4'h5
`define T16WM_M_FP9  4'h6
`define T16WM_M_FP10 4'h7
`define T16WM_M_PFCI 4'h8
`define T16WM_M_PFCA 4'h9
`define T16WM_M_PCI  4'ha
`define T16WM_M_PCA  4'hb
`define T16WM_M_CTCI 4'hc
`define T16WM_M_RSVD 4'hd
`define T16WM_M_FPI  4'he
`define T16WM_M_FPA  4'hf
`define T16WM_TOP8   16'h00ff
`define T16WM_TOP9   16'h01ff
`define T16WM_TOP10  16'h03ff
`define T16WM_MAX    16'hffff
`define T16WM_BOT    16'h0000
`define T16WM_C_OFF  2'h0
`define T16WM_C_TGL  2'h1
`define T16WM_C_CLR  2'h2
`define T16WM_C_SET  2'h3
`endif

// [core/t16wm_pkg.sv]
// t16wm_pkg: types of the waveform timer
// assumes the constants header is included by every user
package t16wm_pkg;
  typedef enum logic [2:0] {
    T16WM_K_NORM = 3'b000,
    T16WM_K_CTC  = 3'b001,
    T16WM_K_PC   = 3'b010,
    T16WM_K_PFC  = 3'b011,
    T16WM_K_FAST = 3'b100,
    T16WM_K_RSVD = 3'b101
  } t16wm_kind_t;
  typedef enum logic {
    T16WM_DOWN = 1'b0,
    T16WM_UP   = 1'b1
  } t16wm_dir_t;
endpackage : t16wm_pkg

// [core/t16wm_chan.sv]
// t16wm_chan: one compare output channel, level held in a flip-flop
// assumes match, top and direction strobes from the counter in the same cycle
`timescale 1ns/1ps
`include "t16wm_consts.svh"
module t16wm_chan (
  input  logic                    clk_in,
  input  logic                    nrst_in,
  input  logic                    tick_in,
  input  t16wm_pkg::t16wm_kind_t  kind_in,
  input  logic [1:0]              com_in,
  input  logic                    toggle_ok_in,
  input  logic                    match_in,
  input  logic                    at_top_in,
  input  logic                    ocr_top_in,
  input  logic                    up_in,
  output logic                    wave_out
);
  logic wave_q;
  logic wave_d;
  logic dual_w;
  assign dual_w = (kind_in == t16wm_pkg::T16WM_K_PC) || (kind_in == t16wm_pkg::T16WM_K_PFC);
  always_comb begin
    wave_d = wave_q;
    if (tick_in && (com_in != `T16WM_C_OFF)) begin
      if (kind_in == t16wm_pkg::T16WM_K_FAST) begin
        if (at_top_in && com_in[1]) begin
          wave_d = ~com_in[0];
        end else if (match_in && !(ocr_top_in && com_in[1])) begin
          if (com_in[1]) begin
            wave_d = com_in[0];
          end else if (toggle_ok_in) begin
            wave_d = ~wave_q;
          end
        end
      end else if (dual_w) begin
        if (match_in && com_in[1]) begin
          wave_d = up_in ? com_in[0] : ~com_in[0];
        end else if (match_in && toggle_ok_in) begin
          wave_d = ~wave_q;
        end
      end else if (match_in) begin
        wave_d = com_in[1] ? com_in[0] : ~wave_q;
      end
    end
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end
  assign wave_out = wave_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_match_clr;
    tick_in && match_in && !dual_w && (kind_in != t16wm_pkg::T16WM_K_FAST)
      && (com_in == `T16WM_C_CLR);
  endsequence
  a_nonpwm_clear: assert property (s_match_clr |=> !wave_q)
    else $error("clear on match did not drive low");
  a_off_holds: assert property (tick_in && (com_in == `T16WM_C_OFF) |=> $stable(wave_q))
    else $error("disconnected channel changed level");
  a_dual_down: assert property (tick_in && match_in && dual_w && !up_in
    && (com_in == `T16WM_C_SET) |=> !wave_q)
    else $error("inverting down match did not clear");
  a_fast_top_set: assert property (tick_in && at_top_in
    && (kind_in == t16wm_pkg::T16WM_K_FAST) && (com_in == `T16WM_C_CLR) |=> wave_q)
    else $error("non-inverting fast pwm not set at top");
endmodule : t16wm_chan

// [core/t16wm_top.sv]
// t16wm_top: 16-bit timer waveform modes, two compare outputs, wishbone registers
// assumes classic single-cycle wishbone master and a one-cycle timer tick input
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "t16wm_consts.svh"
module t16wm_top (
  input  logic        clk_in,
  input  logic        nrst_in,
  input  logic        timer_tick_enable_in,
  input  logic        wb_cyc_in,
  input  logic        wb_stb_in,
  input  logic        wb_we_in,
  input  logic [7:0]  wb_adr_in,
  input  logic [3:0]  wb_sel_in,
  input  logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic        wb_ack_out,
  output logic        irq_out,
  output logic        chan_a_wave_out,
  output logic        chan_a_override_out,
  output logic        chan_a_oe_n_out,
  output logic        chan_b_wave_out,
  output logic        chan_b_override_out,
  output logic        chan_b_oe_n_out
);
  function automatic t16wm_pkg::t16wm_kind_t mode_kind(input logic [3:0] m);
    case (m)
      `T16WM_M_NORM: mode_kind = t16wm_pkg::T16WM_K_NORM;
      `T16WM_M_CTCA, `T16WM_M_CTCI: mode_kind = t16wm_pkg::T16WM_K_CTC;
      `T16WM_M_PFCI, `T16WM_M_PFCA: mode_kind = t16wm_pkg::T16WM_K_PFC;
      `T16WM_M_FP8, `T16WM_M_FP9, `T16WM_M_FP10, `T16WM_M_FPI, `T16WM_M_FPA:
        mode_kind = t16wm_pkg::T16WM_K_FAST;
      `T16WM_M_RSVD: mode_kind = t16wm_pkg::T16WM_K_RSVD;
      default: mode_kind = t16wm_pkg::T16WM_K_PC;
    endcase
  endfunction : mode_kind

  function automatic logic [15:0] mode_top(input logic [3:0] m, input logic [15:0] ca,
                                           input logic [15:0] cap);
    case (m)
      `T16WM_M_PC8, `T16WM_M_FP8:   mode_top = `T16WM_TOP8;
      `T16WM_M_PC9, `T16WM_M_FP9:   mode_top = `T16WM_TOP9;
      `T16WM_M_PC10, `T16WM_M_FP10: mode_top = `T16WM_TOP10;
      `T16WM_M_CTCA, `T16WM_M_PFCA, `T16WM_M_PCA, `T16WM_M_FPA: mode_top = ca;
      `T16WM_M_CTCI, `T16WM_M_PFCI, `T16WM_M_PCI, `T16WM_M_FPI: mode_top = cap;
      default: mode_top = `T16WM_MAX;
    endcase
  endfunction : mode_top

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // register file
  logic [1:0]  com_a_q, com_a_d, com_b_q, com_b_d;
  logic [1:0]  wlo_q, wlo_d, whi_q, whi_d;
  logic [15:0] bufa_q, bufa_d, bufb_q, bufb_d, icr_q, icr_d;
  logic [1:0]  dir_bits_q, dir_bits_d;
  logic [2:0]  ien_q, ien_d;
  logic        wr_w, wr_cnt;
  logic [2:0]  clr_w;

  // counter state
  logic [15:0]            cnt_q, cnt_d, ocra_q, ocra_d, ocrb_q, ocrb_d;
  t16wm_pkg::t16wm_dir_t  cdir_q, cdir_d;
  logic [2:0]             stat_q, stat_d, ev_w;

  // bus and pins
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic        irq_q, irq_d;
  logic        ova_q, ova_d, ovb_q, ovb_d, oea_q, oea_d, oeb_q, oeb_d;

  logic [3:0]             mode_w;
  t16wm_pkg::t16wm_kind_t kind_w;
  logic [15:0]            top_w;
  logic                   tick, dual_w, imm_w, at_top, at_bot, up_w;
  logic                   match_a, match_b, load_w, tgl_a, tgl_b;

  assign mode_w = {whi_q, wlo_q};
  assign kind_w = mode_kind(mode_w);
  assign top_w  = mode_top(mode_w, ocra_q, icr_q);
  assign tick   = timer_tick_enable_in;
  assign dual_w = (kind_w == t16wm_pkg::T16WM_K_PC) || (kind_w == t16wm_pkg::T16WM_K_PFC);
  assign imm_w  = (kind_w == t16wm_pkg::T16WM_K_NORM) || (kind_w == t16wm_pkg::T16WM_K_CTC)
               || (kind_w == t16wm_pkg::T16WM_K_RSVD);
  assign at_top = (cnt_q == top_w);
  assign at_bot = (cnt_q == `T16WM_BOT) && (cdir_q == t16wm_pkg::T16WM_DOWN);
  // top counts as falling, bottom as rising: keeps extreme compares steady
  assign up_w   = (cnt_q == `T16WM_BOT)
               || ((cdir_q == t16wm_pkg::T16WM_UP) && (cnt_q < top_w));
  assign match_a = (cnt_q == ocra_q);
  assign match_b = (cnt_q == ocrb_q);
  assign tgl_a = imm_w
              || ((kind_w == t16wm_pkg::T16WM_K_FAST)
                  && ((mode_w == `T16WM_M_FPI) || (mode_w == `T16WM_M_FPA)))
              || (dual_w && ((mode_w == `T16WM_M_PFCA) || (mode_w == `T16WM_M_PCA)));
  assign tgl_b = imm_w;

  // wishbone: write lands on the edge that sees ack high
  assign wr_w   = wb_cyc_in && wb_stb_in && wb_we_in && ack_q;
  assign wr_cnt = wr_w && (wb_adr_in == `T16WM_A_CNT);
  assign clr_w  = (wr_w && (wb_adr_in == `T16WM_A_CLR) && wb_sel_in[0]) ? wb_dat_in[2:0] : 3'h0;

  always_comb begin
    com_a_d = com_a_q;
    com_b_d = com_b_q;
    wlo_d = wlo_q;
    whi_d = whi_q;
    bufa_d = bufa_q;
    bufb_d = bufb_q;
    icr_d = icr_q;
    dir_bits_d = dir_bits_q;
    ien_d = ien_q;
    if (wr_w) begin
      if (wb_adr_in == `T16WM_A_CTLA && wb_sel_in[0]) begin
        com_a_d = wb_dat_in[`T16WM_F_COMA];
        com_b_d = wb_dat_in[`T16WM_F_COMB];
        wlo_d = wb_dat_in[`T16WM_F_WLO];
      end else if (wb_adr_in == `T16WM_A_CTLB && wb_sel_in[0]) begin
        whi_d = wb_dat_in[`T16WM_F_WHI];
      end else if (wb_adr_in == `T16WM_A_CMPA) begin
        bufa_d = merge16(bufa_q, wb_dat_in, wb_sel_in);
      end else if (wb_adr_in == `T16WM_A_CMPB) begin
        bufb_d = merge16(bufb_q, wb_dat_in, wb_sel_in);
      end else if (wb_adr_in == `T16WM_A_CAPT) begin
        icr_d = merge16(icr_q, wb_dat_in, wb_sel_in);
      end else if (wb_adr_in == `T16WM_A_IEN && wb_sel_in[0]) begin
        ien_d = wb_dat_in[2:0];
      end else if (wb_adr_in == `T16WM_A_DIR && wb_sel_in[0]) begin
        dir_bits_d = wb_dat_in[1:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      com_a_q <= `T16WM_C_OFF;
      com_b_q <= `T16WM_C_OFF;
      wlo_q <= 2'h0;
      whi_q <= 2'h0;
      bufa_q <= `T16WM_BOT;
      bufb_q <= `T16WM_BOT;
      icr_q <= `T16WM_BOT;
      dir_bits_q <= 2'h0;
      ien_q <= 3'h0;
    end else begin
      com_a_q <= com_a_d;
      com_b_q <= com_b_d;
      wlo_q <= wlo_d;
      whi_q <= whi_d;
      bufa_q <= bufa_d;
      bufb_q <= bufb_d;
      icr_q <= icr_d;
      dir_bits_q <= dir_bits_d;
      ien_q <= ien_d;
    end
  end

  // counter, double buffers and flags
  always_comb begin
    cnt_d = cnt_q;
    cdir_d = cdir_q;
    load_w = 1'b0;
    ev_w = 3'h0;
    if (tick) begin
      if (dual_w) begin
        if ((cdir_q == t16wm_pkg::T16WM_UP) && (cnt_q >= top_w)) begin
          cdir_d = t16wm_pkg::T16WM_DOWN;
          cnt_d = cnt_q - 16'h0001;
          load_w = (kind_w == t16wm_pkg::T16WM_K_PC);
        end else if (at_bot) begin
          cdir_d = t16wm_pkg::T16WM_UP;
          cnt_d = cnt_q + 16'h0001;
          load_w = (kind_w == t16wm_pkg::T16WM_K_PFC);
          ev_w[`T16WM_I_OVF] = 1'b1;
        end else begin
          cnt_d = (cdir_q == t16wm_pkg::T16WM_UP) ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
        end
      end else begin
        cdir_d = t16wm_pkg::T16WM_UP;
        cnt_d = at_top ? `T16WM_BOT : cnt_q + 16'h0001;
        if (kind_w == t16wm_pkg::T16WM_K_FAST) begin
          load_w = at_top;
          ev_w[`T16WM_I_OVF] = at_top;
        end else begin
          ev_w[`T16WM_I_OVF] = (cnt_q == `T16WM_MAX);
        end
      end
      ev_w[`T16WM_I_MA] = match_a;
      ev_w[`T16WM_I_MB] = match_b;
    end
    if (wr_cnt) begin
      cnt_d = merge16(cnt_q, wb_dat_in, wb_sel_in);
    end
    ocra_d = (imm_w || load_w) ? bufa_q : ocra_q;
    ocrb_d = (imm_w || load_w) ? bufb_q : ocrb_q;
    stat_d = (stat_q & ~clr_w) | ev_w;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= `T16WM_BOT;
      cdir_q <= t16wm_pkg::T16WM_UP;
      ocra_q <= `T16WM_BOT;
      ocrb_q <= `T16WM_BOT;
      stat_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
      cdir_q <= cdir_d;
      ocra_q <= ocra_d;
      ocrb_q <= ocrb_d;
      stat_q <= stat_d;
    end
  end

  // bus answer, pin control, interrupt
  always_comb begin
    ack_d = wb_cyc_in && wb_stb_in && !ack_q;
    rdat_d = rdat_q;
    if (ack_d) begin
      if (wb_adr_in == `T16WM_A_CTLA) begin
        rdat_d = {24'h0, com_a_q, com_b_q, 2'h0, wlo_q};
      end else if (wb_adr_in == `T16WM_A_CTLB) begin
        rdat_d = {27'h0, whi_q, 3'h0};
      end else if (wb_adr_in == `T16WM_A_CMPA) begin
        rdat_d = {16'h0, bufa_q};
      end else if (wb_adr_in == `T16WM_A_CMPB) begin
        rdat_d = {16'h0, bufb_q};
      end else if (wb_adr_in == `T16WM_A_CAPT) begin
        rdat_d = {16'h0, icr_q};
      end else if (wb_adr_in == `T16WM_A_CNT) begin
        rdat_d = {16'h0, cnt_q};
      end else if (wb_adr_in == `T16WM_A_STAT) begin
        rdat_d = {29'h0, stat_q};
      end else if (wb_adr_in == `T16WM_A_IEN) begin
        rdat_d = {29'h0, ien_q};
      end else if (wb_adr_in == `T16WM_A_DIR) begin
        rdat_d = {30'h0, dir_bits_q};
      end else begin
        rdat_d = 32'h0;
      end
    end
    ova_d = |com_a_q;
    ovb_d = |com_b_q;
    oea_d = !((|com_a_q) && dir_bits_q[0]);
    oeb_d = !((|com_b_q) && dir_bits_q[1]);
    irq_d = |(stat_q & ien_q);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
      ova_q <= 1'b0;
      ovb_q <= 1'b0;
      oea_q <= 1'b1;
      oeb_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ova_q <= ova_d;
      ovb_q <= ovb_d;
      oea_q <= oea_d;
      oeb_q <= oeb_d;
      irq_q <= irq_d;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;
  assign irq_out = irq_q;
  assign chan_a_override_out = ova_q;
  assign chan_b_override_out = ovb_q;
  assign chan_a_oe_n_out = oea_q;
  assign chan_b_oe_n_out = oeb_q;

  t16wm_chan u_chan_a (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .tick_in      (tick),
    .kind_in      (kind_w),
    .com_in       (com_a_q),
    .toggle_ok_in (tgl_a),
    .match_in     (match_a),
    .at_top_in    (at_top),
    .ocr_top_in   (ocra_q == top_w),
    .up_in        (up_w),
    .wave_out     (chan_a_wave_out)
  );

  t16wm_chan u_chan_b (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .tick_in      (tick),
    .kind_in      (kind_w),
    .com_in       (com_b_q),
    .toggle_ok_in (tgl_b),
    .match_in     (match_b),
    .at_top_in    (at_top),
    .ocr_top_in   (ocrb_q == top_w),
    .up_in        (up_w),
    .wave_out     (chan_b_wave_out)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_req;
    wb_cyc_in && wb_stb_in && !ack_q;
  endsequence
  sequence s_fast_wrap;
    tick && (kind_w == t16wm_pkg::T16WM_K_FAST) && at_top && !wr_cnt;
  endsequence
  a_ack_once: assert property (s_req |=> ack_q ##1 !ack_q)
    else $error("ack not a single cycle after request");
  a_drv_needs_dir: assert property (!chan_a_oe_n_out |-> $past(dir_bits_q[0]))
    else $error("channel a driven without output direction");
  a_override_b: assert property ((com_b_q != `T16WM_C_OFF) ##1 $stable(com_b_q)
    |-> chan_b_override_out)
    else $error("channel b pin not handed to waveform");
  a_count_hold: assert property (!tick && !wr_cnt |=> $stable(cnt_q))
    else $error("counter moved without a tick");
  a_norm_wrap: assert property (tick && (mode_w == `T16WM_M_NORM)
    && (cnt_q == `T16WM_MAX) && !wr_cnt |=> (cnt_q == `T16WM_BOT) && stat_q[`T16WM_I_OVF])
    else $error("normal mode did not wrap and flag at max");
  a_fast_wrap: assert property (s_fast_wrap |=> (cnt_q == `T16WM_BOT)
    && stat_q[`T16WM_I_OVF] && (ocra_q == $past(bufa_q)))
    else $error("fast pwm top did not wrap, flag and load");
  a_pfc_bottom: assert property (tick && (kind_w == t16wm_pkg::T16WM_K_PFC) && at_bot
    |=> stat_q[`T16WM_I_OVF] && (ocrb_q == $past(bufb_q)))
    else $error("phase and frequency mode missed bottom load or flag");
  a_pc_top_load: assert property (tick && (kind_w == t16wm_pkg::T16WM_K_PC)
    && (cdir_q == t16wm_pkg::T16WM_UP) && at_top |=> (ocra_q == $past(bufa_q))
    && (cdir_q == t16wm_pkg::T16WM_DOWN))
    else $error("phase correct mode missed top load");
  a_b_no_toggle: assert property (tick && !imm_w
    && (com_b_q == `T16WM_C_TGL) |=> $stable(chan_b_wave_out))
    else $error("channel b toggled in a pwm mode");
  a_irq_level: assert property ((stat_q & ien_q) != 3'h0 |=> irq_out)
    else $error("enabled status did not raise interrupt");
endmodule : t16wm_top

// [verification/t16wm_tb.sv]
// testbench: self-checking bench for the waveform timer with wishbone registers
// assumes one 100 MHz clock, design registers and assertions under core/
`timescale 1ns/1ps
`include "t16wm_consts.svh"
module testbench;
  logic        clk_in;
  logic        nrst_in;
  logic        tick;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic        wa;
  logic        ova;
  logic        oena;
  logic        wb_o;
  logic        ovb;
  logic        oenb;
  logic [31:0] rd;
  int          fail_count;
  int          total_checks;
  int          cycles;
  typedef struct { logic [7:0] a; logic [31:0] w; logic [31:0] e; } t16wm_row_t;
  t16wm_row_t rows [10];
  logic [1:0] codes [4];
  logic       wexp  [4];

  t16wm_top u_t16wm_top (
    .clk_in(clk_in), .nrst_in(nrst_in), .timer_tick_enable_in(tick),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .irq_out(irq), .chan_a_wave_out(wa), .chan_a_override_out(ova),
    .chan_a_oe_n_out(oena), .chan_b_wave_out(wb_o), .chan_b_override_out(ovb),
    .chan_b_oe_n_out(oenb)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    // wait for ack however long it takes; only the cycle ceiling ends a hang
    do begin
      @(posedge clk_in);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  task automatic run(input int n);
    @(posedge clk_in);
    tick <= 1'b1;
    repeat (n) @(posedge clk_in);
    tick <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : run

  task automatic mode(input logic [7:0] ca, input logic [7:0] cb); // never mode 13
    wb(1'b1, `T16WM_A_CTLA, {24'h0, ca});
    wb(1'b1, `T16WM_A_CTLB, {24'h0, cb});
  endtask : mode

  initial begin
    nrst_in = 1'b0; tick = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; sel = 4'h0; wdat = 32'h0; fail_count = 0; total_checks = 0; cycles = 0;
    rows = '{'{`T16WM_A_CTLA, 32'hf3, 32'hf3}, '{`T16WM_A_CTLA, 32'hff, 32'hf3},
             '{`T16WM_A_CTLB, 32'hff, 32'h18}, '{`T16WM_A_CMPA, 32'h1234, 32'h1234},
             '{`T16WM_A_CMPB, 32'h00a5, 32'h00a5}, '{`T16WM_A_CAPT, 32'hbeef, 32'hbeef},
             '{`T16WM_A_DIR, 32'hff, 32'h3}, '{`T16WM_A_STAT, 32'h7, 32'h0},
             '{`T16WM_A_CLR, 32'h7, 32'h0}, '{8'h40, 32'h55, 32'h0}};
    codes = '{2'h1, 2'h2, 2'h3, 2'h1};
    wexp = '{1'b1, 1'b0, 1'b1, 1'b0};
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    chk({wa, ova, oena, wb_o, ovb, oenb, irq}, 7'h12, "reset pins");
    foreach (rows[i]) begin
      wb(1'b1, rows[i].a, rows[i].w);
      wb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e, "register row");
    end
    $display("register table done");
    @(posedge clk_in) nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({wa, ova, oena, ovb, oenb, irq}, 6'h0a, "mid reset pins");
    nrst_in <= 1'b1;
    wb(1'b0, `T16WM_A_CTLA, 32'h0);
    chk(rd, 32'h0, "control a after reset");
    $display("reset test done");
    mode(8'h81, 8'h08);
    wb(1'b1, `T16WM_A_CMPA, 32'h10);
    wb(1'b1, `T16WM_A_CNT, 32'hff);
    chk({ova, oena, ovb}, 3'h6, "override dir off");
    wb(1'b1, `T16WM_A_DIR, 32'h1);
    repeat (2) @(posedge clk_in);
    chk({ova, oena, oenb}, 3'h5, "override dir on");
    run(1);
    chk({31'h0, wa}, 32'h1, "fast set at bottom");
    wb(1'b0, `T16WM_A_STAT, 32'h0);
    chk(rd & 32'h1, 32'h1, "fast overflow at top");
    wb(1'b1, `T16WM_A_CNT, 32'h0f);
    run(2);
    chk({31'h0, wa}, 32'h0, "fast clear on match");
    wb(1'b1, `T16WM_A_CTLA, 32'h41);
    wb(1'b1, `T16WM_A_CNT, 32'h0f);
    run(2);
    chk({31'h0, wa}, 32'h0, "fast toggle refused");
    wb(1'b1, `T16WM_A_CNT, 32'h0);
    run(300);
    wb(1'b0, `T16WM_A_CNT, 32'h0);
    chk(rd, 32'h2c, "fast 8-bit wrap");
    $display("fast pwm test done");
    mode(8'h00, 8'h00);
    wb(1'b1, `T16WM_A_CMPA, 32'h30);
    wb(1'b1, `T16WM_A_CLR, 32'h7);
    wb(1'b1, `T16WM_A_IEN, 32'h2);
    foreach (codes[i]) begin
      wb(1'b1, `T16WM_A_CTLA, {24'h0, codes[i], 6'h0});
      wb(1'b1, `T16WM_A_CNT, 32'h2f);
      run(2);
      chk({31'h0, wa}, {31'h0, wexp[i]}, "normal mode code");
    end
    chk({31'h0, irq}, 32'h1, "irq raised");
    wb(1'b1, `T16WM_A_IEN, 32'h0);
    repeat (2) @(posedge clk_in);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wb(1'b1, `T16WM_A_IEN, 32'h2);
    wb(1'b1, `T16WM_A_CLR, 32'h2);
    @(posedge clk_in);
    wb(1'b0, `T16WM_A_STAT, 32'h0);
    chk({rd[1], irq}, 2'h0, "irq cleared");
    $display("normal mode test done");
    mode(8'h00, 8'h08);
    wb(1'b1, `T16WM_A_CMPA, 32'h20);
    wb(1'b1, `T16WM_A_CNT, 32'h0);
    run(70);
    wb(1'b0, `T16WM_A_CNT, 32'h0);
    chk(rd, 32'h4, "ctc top compare a");
    $display("ctc test done");
    mode(8'h81, 8'h00);
    wb(1'b1, `T16WM_A_CMPA, 32'h10);
    wb(1'b1, `T16WM_A_CNT, 32'h0);
    wb(1'b1, `T16WM_A_CLR, 32'h7);
    run(505);
    chk({31'h0, wa}, 32'h1, "dual set on down match");
    run(35);
    chk({31'h0, wa}, 32'h0, "dual clear on up match");
    wb(1'b0, `T16WM_A_CNT, 32'h0);
    chk(rd, 32'h1e, "dual 8-bit count");
    wb(1'b0, `T16WM_A_STAT, 32'h0);
    chk(rd & 32'h1, 32'h1, "dual overflow at bottom");
    $display("dual slope test done");
    // normal mode for one write so compare b loads at once; b matches only at top
    wb(1'b1, `T16WM_A_CTLA, 32'h0);
    wb(1'b1, `T16WM_A_CMPB, 32'h10);
    mode(8'h51, 8'h10);
    wb(1'b1, `T16WM_A_CNT, 32'h0);
    wb(1'b1, `T16WM_A_CLR, 32'h7);
    run(33);
    chk({30'h0, wa, wb_o}, 32'h2, "pfc toggle on a only");
    wb(1'b0, `T16WM_A_CNT, 32'h0);
    chk(rd, 32'h1, "pfc turn at compare a top");
    wb(1'b0, `T16WM_A_STAT, 32'h0);
    chk(rd & 32'h1, 32'h1, "pfc overflow at bottom");
    $display("phase and frequency test done");
    give_verdict();
  end
endmodule : testbench
